// File: verilog/sysio_defines.svh
// constants for the system i/o port glue: offsets, bit positions, resets, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef SYSIO_DEFINES_SVH
`define SYSIO_DEFINES_SVH

`define ADDR_MISC        8'h09
`define ADDR_CNT0        8'h0c
`define ADDR_CNT1        8'h0d
`define ADDR_CNT2        8'h0e
`define ADDR_CNT3        8'h0f
`define ADDR_PRN_CTRL    8'h10
`define ADDR_PRN_DATA    8'h11
`define ADDR_IRQ_STAT    8'h12
`define ADDR_IRQ_MASK    8'h13
`define ADDR_FLOPPY_CTRL 8'h14

`define MISC_DRIVE_TYPE  7
`define MISC_BOARD       6
`define MISC_BANK_HI     4
`define MISC_BANK_LO     3
`define MISC_DISK_CHG    2
`define MISC_FDC_RST     1
`define MISC_COPROC      0

`define PRN_AUX          7
`define PRN_SELECT       6
`define PRN_BUSY         5
`define PRN_PAPER_EMPTY  4
`define PRN_FAULT        3
`define PRN_INIT         1
`define PRN_STROBE       0

`define FLOPPY_DENSITY   0

`define IRQ_DISK_CHG     0
`define IRQ_COPROC       1
`define IRQ_CNT0         2
`define IRQ_FAULT        6
`define IRQ_W            7

`define BANK_RST         2'h0
`define DENSITY_RST      1'h0
`define PRN_DATA_RST     8'h00
`define PRN_CTRL_RST     2'h0
`define IRQ_MASK_RST     7'h00
`define CNT_TC_RST       8'h00

`define CLK_HZ           20000000
`define TICK_HZ          2000000
`define TICK_DIV         (`CLK_HZ / `TICK_HZ)
`define FDC_RST_US       50
`define FDC_RST_CYCLES   ((`FDC_RST_US * `CLK_HZ + 999999) / 1000000)

`endif

// File: verilog/sysio_pkg.sv
// types shared by the system i/o port glue and its counter channel
// assumes sysio_defines.svh is on the include path
package sysio_pkg;
	`include "sysio_defines.svh"

	typedef enum logic [0:0] {
		FDC_IDLE  = 1'b0,
		FDC_PULSE = 1'b1
	} fdc_state_t;

	typedef struct packed {
		logic drive_type;
		logic board_variant;
		logic disk_change_n;
		logic coproc_end;
		logic index_pulse;
		logic prn_aux;
		logic prn_select;
		logic prn_busy;
		logic prn_paper_empty;
		logic prn_fault;
	} pins_t;

	typedef struct packed {
		logic [7:0] tc;
		logic [7:0] count;
		logic       zero;
		logic       out;
	} cnt_state_t;

	typedef struct packed {
		pins_t           sync1;
		pins_t           sync2;
		pins_t           prev;
		logic [7:0]      rdata;
		logic            irq;
		logic [6:0]      irq_stat;
		logic [6:0]      irq_mask;
		logic [1:0]      bank;
		logic            coproc_reset;
		logic            density_n;
		logic [1:0]      prn_ctrl;
		logic [7:0]      prn_data;
		fdc_state_t      fdc_state;
		logic [9:0]      fdc_cnt;
		logic            fdc_reset_n;
		logic [3:0]      tick_div;
		logic            tick;
	} main_state_t;
endpackage

// File: verilog/counter_channel.sv
// one counter/timer channel: 8-bit down counter with reload and toggled output
// assumes i_tick is a one-cycle pulse in the i_clk domain
`timescale 1ns/10ps
`include "sysio_defines.svh"
module counter_channel
	import sysio_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic       i_tick,
	input  wire logic       i_load,
	input  wire logic [7:0] i_tc,
	output logic      [7:0] o_count,
	output logic            o_zero,
	output logic            o_out
);
	cnt_state_t q;
	cnt_state_t d;

	always_comb begin
		d = q;
		d.zero = 1'b0;
		if (i_srst) begin
			d = '0;
			d.tc = `CNT_TC_RST;
			d.count = `CNT_TC_RST;
		end else if (i_load) begin
			// load wins over a tick in the same cycle
			d.tc = i_tc;
			d.count = i_tc;
		end else if (i_tick) begin
			// a constant of zero gives a full 256-count period
			if (q.count == 8'h01) begin
				d.count = q.tc;
				d.zero = 1'b1;
				d.out = ~q.out;
			end else begin
				d.count = q.count - 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		q <= d;
	end

	assign o_count = q.count;
	assign o_zero  = q.zero;
	assign o_out   = q.out;
endmodule

// File: verilog/system_io_port_glue.sv
// system i/o port glue: misc config port, four counter channels, printer ports
// assumes a single 20 MHz clock; all pin inputs are asynchronous to it
//
// How it works
// [R01] misc bit 7 reads drive-type switch
// [R02] misc bit 6 reads board-variant switch
// [R03] misc bits 4:3 select memory bank
// [R04] misc bit 2 reads active-low disk change
// [R05] misc bit 1 low pulses fdc reset 50us
// [R06] bit 0 reads coproc end or drives reset
// [R07] density output: 0 double, 1 single
// [R08] channel 0 on 2 MHz, baud clock A
// [R09] channel 1 on 2 MHz, output unused
// [R10] channel 2 on 2 MHz, baud clock B
// [R11] channel 3 counts floppy index pulses
// [R12] printer status inputs readable by software
// [R13] printer strobe and init are outputs
// [R14] printer data port drives eight bits
// [R15] misc bit 5 unused, reads zero
// [R16] reads show pins, writes only outputs
// [R17] density is floppy control bit 0, low active
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "sysio_defines.svh"
module system_io_port_glue
	import sysio_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_irq,
	input  wire logic       i_drive_type,
	input  wire logic       i_board_variant,
	input  wire logic       i_disk_change_n,
	input  wire logic       i_coproc_end,
	input  wire logic       i_index_pulse,
	input  wire logic       i_prn_aux,
	input  wire logic       i_prn_select,
	input  wire logic       i_prn_busy,
	input  wire logic       i_prn_paper_empty,
	input  wire logic       i_prn_fault,
	output logic      [1:0] o_bank_sel,
	output logic            o_fdc_reset_n,
	output logic            o_coproc_reset,
	output logic            o_density_sel_n,
	output logic            o_baud_clk_a,
	output logic            o_baud_clk_b,
	output logic            o_printer_strobe,
	output logic            o_printer_init,
	output logic      [7:0] o_printer_data
);
	localparam logic [9:0] FDC_LAST = 10'(`FDC_RST_CYCLES - 1);
	localparam logic [3:0] DIV_LAST = 4'(`TICK_DIV - 1);

	main_state_t q;
	main_state_t d;

	pins_t      pin_raw;
	logic [3:0] cnt_tick;
	logic [3:0] cnt_load;
	logic [3:0] cnt_zero;
	logic [3:0] cnt_out;
	logic [7:0] cnt_val [4];
	logic       wr_misc;
	logic       index_rise;
	logic [6:0] irq_event;
	logic [6:0] irq_clr;

	always_comb begin
		pin_raw.drive_type      = i_drive_type;
		pin_raw.board_variant   = i_board_variant;
		pin_raw.disk_change_n   = i_disk_change_n;
		pin_raw.coproc_end      = i_coproc_end;
		pin_raw.index_pulse     = i_index_pulse;
		pin_raw.prn_aux         = i_prn_aux;
		pin_raw.prn_select      = i_prn_select;
		pin_raw.prn_busy        = i_prn_busy;
		pin_raw.prn_paper_empty = i_prn_paper_empty;
		pin_raw.prn_fault       = i_prn_fault;
	end

	assign wr_misc    = i_wr && (i_addr == `ADDR_MISC);
	// edge taken from the second sync stage only
	assign index_rise = q.sync2.index_pulse && !q.prev.index_pulse;

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_cnt
			// [R08] [R09] [R10] 2 MHz tick source
			// [R11] channel 3 on index edges
			assign cnt_tick[ch] = (ch == 3) ? index_rise : q.tick;
			assign cnt_load[ch] = i_wr && (i_addr == 8'(`ADDR_CNT0 + ch));
			counter_channel u_cnt (
				.i_clk   (i_clk),
				.i_srst  (i_srst),
				.i_tick  (cnt_tick[ch]),
				.i_load  (cnt_load[ch]),
				.i_tc    (i_wdata),
				.o_count (cnt_val[ch]),
				.o_zero  (cnt_zero[ch]),
				.o_out   (cnt_out[ch])
			);
		end
	endgenerate

	always_comb begin
		irq_event = '0;
		irq_event[`IRQ_DISK_CHG] = q.prev.disk_change_n && !q.sync2.disk_change_n;
		irq_event[`IRQ_COPROC] = q.sync2.board_variant && q.sync2.coproc_end
			&& !q.prev.coproc_end;
		irq_event[`IRQ_CNT0 +: 4] = cnt_zero;
		irq_event[`IRQ_FAULT] = q.sync2.prn_fault && !q.prev.prn_fault;
		irq_clr = (i_wr && (i_addr == `ADDR_IRQ_STAT)) ? i_wdata[6:0] : 7'h00;
	end

	always_comb begin
		d = q;
		d.sync1 = pin_raw;
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		d.rdata = 8'h00;

		// 2 MHz tick for the baud channels
		if (q.tick_div == DIV_LAST) begin
			d.tick_div = 4'h0;
			d.tick = 1'b1;
		end else begin
			d.tick_div = q.tick_div + 4'h1;
			d.tick = 1'b0;
		end

		// set beats a same-cycle clear
		d.irq_stat = (q.irq_stat & ~irq_clr) | irq_event;
		if (i_wr && (i_addr == `ADDR_IRQ_MASK)) begin
			d.irq_mask = i_wdata[6:0];
		end

		// [R05] timed fdc reset pulse
		case (q.fdc_state)
			FDC_IDLE: begin
				d.fdc_reset_n = 1'b1;
				if (wr_misc && !i_wdata[`MISC_FDC_RST]) begin
					d.fdc_state = FDC_PULSE;
					d.fdc_cnt = FDC_LAST;
					d.fdc_reset_n = 1'b0;
				end
			end
			FDC_PULSE: begin
				// a further low write restarts the full width
				if (wr_misc && !i_wdata[`MISC_FDC_RST]) begin
					d.fdc_cnt = FDC_LAST;
				end else if (q.fdc_cnt == 10'h000) begin
					d.fdc_state = FDC_IDLE;
					d.fdc_reset_n = 1'b1;
				end else begin
					d.fdc_cnt = q.fdc_cnt - 10'h001;
				end
			end
			default: begin
				d.fdc_state = FDC_IDLE;
				d.fdc_reset_n = 1'b1;
			end
		endcase

		if (wr_misc) begin
			// [R03] bank number, bit 4 high
			d.bank = {i_wdata[`MISC_BANK_HI], i_wdata[`MISC_BANK_LO]};
			// [R06] earlier boards drive coproc reset
			if (!q.sync2.board_variant) begin
				d.coproc_reset = i_wdata[`MISC_COPROC];
			end
			// [R15] bit 5 written, nothing kept
		end

		// [R07] [R17] density select bit
		if (i_wr && (i_addr == `ADDR_FLOPPY_CTRL)) begin
			d.density_n = i_wdata[`FLOPPY_DENSITY];
		end

		// [R13] [R16] only output bits are stored
		if (i_wr && (i_addr == `ADDR_PRN_CTRL)) begin
			d.prn_ctrl = {i_wdata[`PRN_INIT], i_wdata[`PRN_STROBE]};
		end

		// [R14] full data byte
		if (i_wr && (i_addr == `ADDR_PRN_DATA)) begin
			d.prn_data = i_wdata;
		end

		if (i_rd) begin
			case (i_addr)
				`ADDR_MISC: begin
					// [R01] drive type switch
					d.rdata[`MISC_DRIVE_TYPE] = q.sync2.drive_type;
					// [R02] board variant switch
					d.rdata[`MISC_BOARD] = q.sync2.board_variant;
					// [R15] unused bit reads zero
					d.rdata[5] = 1'b0;
					d.rdata[`MISC_BANK_HI] = q.bank[1];
					d.rdata[`MISC_BANK_LO] = q.bank[0];
					// [R04] disk change, low active
					d.rdata[`MISC_DISK_CHG] = q.sync2.disk_change_n;
					d.rdata[`MISC_FDC_RST] = q.fdc_reset_n;
					// [R06] later board reads end flag
					d.rdata[`MISC_COPROC] = q.sync2.board_variant ? q.sync2.coproc_end
						: q.coproc_reset;
				end
				`ADDR_CNT0: begin
					d.rdata = cnt_val[0];
				end
				`ADDR_CNT1: begin
					d.rdata = cnt_val[1];
				end
				`ADDR_CNT2: begin
					d.rdata = cnt_val[2];
				end
				`ADDR_CNT3: begin
					d.rdata = cnt_val[3];
				end
				`ADDR_PRN_CTRL: begin
					// [R12] [R16] printer status pins
					d.rdata[`PRN_AUX] = q.sync2.prn_aux;
					d.rdata[`PRN_SELECT] = q.sync2.prn_select;
					d.rdata[`PRN_BUSY] = q.sync2.prn_busy;
					d.rdata[`PRN_PAPER_EMPTY] = q.sync2.prn_paper_empty;
					d.rdata[`PRN_FAULT] = q.sync2.prn_fault;
					d.rdata[`PRN_INIT] = q.prn_ctrl[1];
					d.rdata[`PRN_STROBE] = q.prn_ctrl[0];
				end
				`ADDR_PRN_DATA: begin
					d.rdata = q.prn_data;
				end
				`ADDR_IRQ_STAT: begin
					d.rdata = {1'b0, q.irq_stat};
				end
				`ADDR_IRQ_MASK: begin
					d.rdata = {1'b0, q.irq_mask};
				end
				`ADDR_FLOPPY_CTRL: begin
					d.rdata[`FLOPPY_DENSITY] = q.density_n;
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end

		d.irq = |(d.irq_stat & d.irq_mask);

		if (i_srst) begin
			d = '0;
			d.bank = `BANK_RST;
			d.density_n = `DENSITY_RST;
			d.prn_ctrl = `PRN_CTRL_RST;
			d.prn_data = `PRN_DATA_RST;
			d.irq_mask = `IRQ_MASK_RST;
			d.fdc_state = FDC_IDLE;
			d.fdc_reset_n = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		q <= d;
	end

	// baud clocks come from counter output flops
	assign o_rdata          = q.rdata;
	assign o_irq            = q.irq;
	assign o_bank_sel       = q.bank;
	assign o_fdc_reset_n    = q.fdc_reset_n;
	assign o_coproc_reset   = q.coproc_reset;
	assign o_density_sel_n  = q.density_n;
	assign o_baud_clk_a     = cnt_out[0];
	assign o_baud_clk_b     = cnt_out[2];
	assign o_printer_strobe = q.prn_ctrl[0];
	assign o_printer_init   = q.prn_ctrl[1];
	assign o_printer_data   = q.prn_data;
endmodule

// File: test/sysio_asserts.sv
// checker for the i/o glue: register writes, read data timing, fdc pulse
// assumes bind onto system_io_port_glue, one clock, sync reset
`timescale 1ns/10ps
module sysio_asserts (
	input wire logic       i_clk,
	input wire logic       i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       o_irq,
	input wire logic       i_drive_type,
	input wire logic       i_board_variant,
	input wire logic       i_disk_change_n,
	input wire logic [1:0] o_bank_sel,
	input wire logic       o_fdc_reset_n,
	input wire logic       o_density_sel_n,
	input wire logic       o_printer_strobe,
	input wire logic       o_printer_init,
	input wire logic [7:0] o_printer_data
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic [10:0] low_cnt_q;
	// low samples since last start; a restart zeroes it
	always_ff @(posedge i_clk) begin
		if (i_srst || o_fdc_reset_n || (i_wr && i_addr == 8'h09 && !i_wdata[1])) begin
			low_cnt_q <= 11'h000;
		end else begin
			low_cnt_q <= low_cnt_q + 11'h001;
		end
	end
	sequence s_wr(a);
		i_wr && i_addr == a;
	endsequence
	sequence s_still;
		$stable({i_drive_type, i_board_variant, i_disk_change_n})[*3];
	endsequence
	property p_bank;
		s_wr(8'h09) |=> o_bank_sel == $past(i_wdata[4:3]);
	endproperty
	property p_prn_data;
		s_wr(8'h11) |=> o_printer_data == $past(i_wdata);
	endproperty
	property p_prn_ctrl;
		s_wr(8'h10) |=> {o_printer_init, o_printer_strobe} == $past(i_wdata[1:0]);
	endproperty
	property p_density;
		s_wr(8'h14) |=> o_density_sel_n == $past(i_wdata[0]);
	endproperty
	property p_mask_off;
		s_wr(8'h13) ##0 i_wdata[6:0] == 7'h00 |=> !o_irq;
	endproperty
	property p_fdc_start;
		s_wr(8'h09) ##0 !i_wdata[1] |=> !o_fdc_reset_n;
	endproperty
	property p_fdc_len;
		$rose(o_fdc_reset_n) |-> low_cnt_q == 11'd1000;
	endproperty
	property p_fdc_max;
		!o_fdc_reset_n |-> low_cnt_q < 11'd1000;
	endproperty
	property p_misc_rd;
		s_still ##0 i_rd && i_addr == 8'h09 |=> o_rdata[2] == $past(i_disk_change_n)
			&& o_rdata[7:5] == {$past(i_drive_type), $past(i_board_variant), 1'b0};
	endproperty
	property p_rd_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	a_prn_data: assert property (p_prn_data) else $error("printer data wrong");
	a_prn_ctrl: assert property (p_prn_ctrl) else $error("printer ctrl wrong");
	a_density: assert property (p_density) else $error("density wrong");
	a_mask_off: assert property (p_mask_off) else $error("irq with mask 0");
	a_fdc_start: assert property (p_fdc_start) else $error("fdc reset not low");
	a_fdc_len: assert property (p_fdc_len) else $error("fdc pulse length");
	a_fdc_max: assert property (p_fdc_max) else $error("fdc pulse too long");
	a_misc_rd: assert property (p_misc_rd) else $error("misc pins");
	a_rd_idle: assert property (p_rd_idle) else $error("read data not 0");
endmodule
bind system_io_port_glue sysio_asserts u_chk (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_irq, .i_drive_type, .i_board_variant, .i_disk_change_n,
	.o_bank_sel, .o_fdc_reset_n, .o_density_sel_n, .o_printer_strobe, .o_printer_init,
	.o_printer_data);

// File: test/host_model.sv
// host processor model: one-cycle register writes and reads
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/10ps
module host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		// released bus shows no stale data
		o_wdata <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule

// File: test/tb.sv
// testbench for the system i/o glue, host model drives the register port
// assumes 20 MHz clock; pins change 1 ns after rising edges
`timescale 1ns/10ps
module tb;
	import sysio_pkg::*;
	logic       i_clk, i_srst, i_wr, i_rd, o_irq, o_fdc_reset_n, o_coproc_reset;
	logic       i_drive_type, i_board_variant, i_disk_change_n, i_coproc_end;
	logic       i_index_pulse, i_prn_aux, i_prn_select, i_prn_busy;
	logic       i_prn_paper_empty, i_prn_fault, o_density_sel_n, o_baud_clk_a;
	logic       o_baud_clk_b, o_printer_strobe, o_printer_init;
	logic [7:0] i_addr, i_wdata, o_rdata, o_printer_data, d;
	logic [1:0] o_bank_sel;
	pins_t      pin;
	int         failures, n_tests, c;
	logic [7:0] rows [5][3] = '{'{8'h11, 8'ha5, 8'ha5}, '{8'h11, 8'h5a, 8'h5a},
		'{8'h13, 8'h15, 8'h15}, '{8'h13, 8'h6a, 8'h6a}, '{8'h20, 8'hff, 8'h00}};
	assign {i_drive_type, i_board_variant, i_disk_change_n, i_coproc_end, i_index_pulse,
		i_prn_aux, i_prn_select, i_prn_busy, i_prn_paper_empty, i_prn_fault} = pin;
	system_io_port_glue i_system_io_port_glue (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .o_irq, .i_drive_type, .i_board_variant, .i_disk_change_n,
		.i_coproc_end, .i_index_pulse, .i_prn_aux, .i_prn_select, .i_prn_busy,
		.i_prn_paper_empty, .i_prn_fault, .o_bank_sel, .o_fdc_reset_n, .o_coproc_reset,
		.o_density_sel_n, .o_baud_clk_a, .o_baud_clk_b, .o_printer_strobe,
		.o_printer_init, .o_printer_data);
	host_model u_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// cycles until the chosen baud output moves, bounded
	task automatic tog(input logic b, output int n);
		logic s;
		s = b ? o_baud_clk_b : o_baud_clk_a;
		n = 0;
		while ((b ? o_baud_clk_b : o_baud_clk_a) === s && n < 600) begin
			edges(1);
			n++;
		end
		if (n >= 600) begin
			failures++;
			stop_test();
		end
	endtask
	initial begin
		i_srst = 1'b1;
		pin = '0;
		failures = 0;
		n_tests = 0;
		edges(20);
		i_srst <= 1'b0;
		edges(1);
		chk("reset", {o_fdc_reset_n, o_bank_sel, o_density_sel_n, o_irq, o_printer_data,
			o_printer_strobe, o_printer_init}, 16'h4000);
		foreach (rows[k]) begin
			u_host.wr(rows[k][0], rows[k][1]);
			u_host.rd(rows[k][0], d);
			chk("row", {rows[k][0], d}, {rows[k][0], rows[k][2]});
		end
		chk("prn_data", o_printer_data, 8'h5a);
		pin <= 10'b1010000000;
		u_host.wr(8'h09, 8'h1b);
		u_host.rd(8'h09, d);
		chk("misc", {o_bank_sel, o_coproc_reset, d}, {2'h3, 1'b1, 8'h9f});
		u_host.wr(8'h13, 8'h02);
		pin <= 10'b0110000000;
		edges(4);
		pin <= 10'b0111000000;
		edges(4);
		u_host.rd(8'h09, d);
		chk("misc_end", {o_irq, d}, {1'b1, 8'h5f});
		u_host.rd(8'h12, d);
		chk("status", d & 8'h02, 8'h02);
		u_host.wr(8'h13, 8'h00);
		chk("irq_masked", o_irq, 1'b0);
		u_host.wr(8'h13, 8'h02);
		chk("irq_unmasked", o_irq, 1'b1);
		u_host.wr(8'h12, 8'h02);
		chk("irq_cleared", o_irq, 1'b0);
		pin <= 10'b0111010101;
		u_host.wr(8'h10, 8'h03);
		u_host.rd(8'h10, d);
		chk("prn_ctrl", {o_printer_strobe, o_printer_init, d}, {2'h3, 8'hab});
		for (c = 1; c >= 0; c--) begin
			u_host.wr(8'h14, 8'(c));
			chk("density", o_density_sel_n, c[0]);
		end
		u_host.wr(8'h09, 8'h19);
		chk("fdc_low", o_fdc_reset_n, 1'b0);
		u_host.rd(8'h09, d);
		chk("fdc_read", d[1], 1'b0);
		c = 0;
		while (!o_fdc_reset_n && c < 2000) begin
			edges(1);
			c++;
		end
		chk("fdc_len", 16'(c + 2), 16'd1000);
		u_host.wr(8'h0c, 8'h02);
		tog(1'b0, c);
		tog(1'b0, c);
		chk("baud_a", 16'(c), 16'd20);
		u_host.wr(8'h0e, 8'h05);
		tog(1'b1, c);
		tog(1'b1, c);
		chk("baud_b", 16'(c), 16'd50);
		u_host.wr(8'h0f, 8'h03);
		repeat (2) begin
			pin.index_pulse <= 1'b1;
			edges(4);
			pin.index_pulse <= 1'b0;
			edges(4);
		end
		u_host.rd(8'h0f, d);
		chk("index_count", d, 8'h01);
		u_host.wr(8'h0d, 8'h05);
		// any 20 edges hold exactly two ticks
		edges(19);
		u_host.rd(8'h0d, d);
		chk("count1", d, 8'h03);
		pin.disk_change_n <= 1'b0;
		edges(4);
		u_host.rd(8'h12, d);
		chk("disk_chg", {d[6], d[0]}, 2'h3);
		i_srst <= 1'b1;
		edges(2);
		i_srst <= 1'b0;
		edges(1);
		chk("rst_mid", {o_bank_sel, o_coproc_reset, o_printer_data, o_fdc_reset_n},
			16'h0001);
		stop_test();
	end
endmodule
